/* File: design/ndh_pkg.sv */
// Purpose: Constants and types for the NAND bus host controller.
// Assumes: Eight-bit NAND bus, APB register port, 10 MHz pclk.
// Notes: Offsets are byte addresses of 32-bit registers.
package ndh_pkg;
    // ----------------------------------------------------------------
    // Register map
    // ----------------------------------------------------------------
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_TXB = 8'h04;
    localparam logic [7:0] OFF_COL = 8'h08;
    localparam logic [7:0] OFF_ROW = 8'h0C;
    localparam logic [7:0] OFF_CFG = 8'h10;
    localparam logic [7:0] OFF_STAT = 8'h14;
    // ----------------------------------------------------------------
    // Field positions and reset values
    // ----------------------------------------------------------------
    localparam int CFG_WP_N = 0;
    localparam int CFG_LOCK = 1;
    localparam int CFG_CE_KEEP = 2;
    localparam int STAT_BUSY = 0;
    localparam int STAT_RDY = 1;
    localparam int STAT_RDATA = 8;
    localparam int COL_TOP = 11;
    localparam logic RST_WP_N = 1'b0;
    localparam logic RST_LOCK = 1'b0;
    localparam logic RST_CE_KEEP = 1'b0;
    // ----------------------------------------------------------------
    // Operation codes written to the control register
    // ----------------------------------------------------------------
    localparam logic [2:0] OP_NONE = 3'h0;
    localparam logic [2:0] OP_CMD = 3'h1;
    localparam logic [2:0] OP_ADDR = 3'h2;
    localparam logic [2:0] OP_WDATA = 3'h3;
    localparam logic [2:0] OP_RDATA = 3'h4;
    localparam logic [2:0] OP_ADDR5 = 3'h5;
    localparam logic [2:0] ADDR_LAST = 3'h4;
    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int CLK_NS = 100;
    localparam int STROBE_NS = 300;
    localparam int STROBE_CYC = (STROBE_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [3:0] STROBE_LAST = 4'(STROBE_CYC - 1);
    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_SETUP = 4'b0010,
        ST_PULSE = 4'b0100,
        ST_RELEASE = 4'b1000
    } ndh_state_t;
    typedef struct packed {
        ndh_state_t st;
        logic [2:0] op;
        logic [2:0] idx;
        logic [3:0] cnt;
        logic [7:0] txb;
        logic [11:0] col;
        logic [16:0] row;
        logic wp_n;
        logic lock;
        logic ce_keep;
        logic [7:0] rdata;
        logic ce_n;
        logic cle;
        logic ale;
        logic we_n;
        logic re_n;
        logic [7:0] io_out;
        logic io_oe;
        logic rb_m;
        logic rb_s;
        logic [7:0] io_m;
        logic [7:0] io_s;
    } ndh_regs_t;
endpackage : ndh_pkg

/* File: design/ndh_host.sv */
// Purpose: Host controller that drives a NAND die over its strobed bus.
// Assumes: Software orders single bus cycles or a five-cycle address.
// Notes: APB slave with zero wait states; pins are sampled through two flops.
//
// The placing of the registers and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
// Contract
// - Commands, addresses and data share one byte-wide two-way bus.
// - Five control strobes plus separate write protect and ready/busy.
// - Host read strobe moves one datum out of the die per strobe.
// - Host write strobe moves one command, address or datum per strobe.
// - Five address cycles: column low, column high, page, block, block top.
// - With top column bit set, column bits 10 to 6 are zero.
// - Command latched on write strobe rise with ce low, cle high, ale low.
// - Address latched on write strobe rise with ce low, ale high, cle low.
module ndh_host (
    // Clock and reset.
    input wire logic pclk,
    input wire logic presetn,
    // APB slave.
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // NAND bus pins.
    output logic ce_n,
    output logic cle,
    output logic ale,
    output logic we_n,
    output logic read_strobe_n,
    output logic [7:0] io_out,
    output logic io_oe,
    input wire logic [7:0] io_in,
    // Side pins.
    output logic wp_n,
    output logic lock,
    input wire logic rb_n
);
    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    function automatic logic [7:0] addr_byte(input logic [2:0] idx,
        input logic [11:0] col, input logic [16:0] row);
        case (idx)
            3'h0: addr_byte = col[7:0];
            3'h1: addr_byte = {4'h0, col[11:8]};
            3'h2: addr_byte = row[7:0];
            3'h3: addr_byte = row[15:8];
            default: addr_byte = {7'h00, row[16]};
        endcase
    endfunction : addr_byte

    function automatic logic [11:0] spare_mask(input logic [11:0] col);
        spare_mask = col[ndh_pkg::COL_TOP] ? {col[11], 5'h00, col[5:0]} : col;
    endfunction : spare_mask

    ndh_pkg::ndh_regs_t s;
    ndh_pkg::ndh_regs_t next_s;
    logic wr;
    logic acc;
    logic mapped;
    logic busy;

    assign acc = psel && penable;
    assign wr = acc && pwrite;
    assign busy = (s.st != ndh_pkg::ST_IDLE);
    assign mapped = (paddr == ndh_pkg::OFF_CTRL) || (paddr == ndh_pkg::OFF_TXB)
        || (paddr == ndh_pkg::OFF_COL) || (paddr == ndh_pkg::OFF_ROW)
        || (paddr == ndh_pkg::OFF_CFG) || (paddr == ndh_pkg::OFF_STAT);
    // ----------------------------------------------------------------
    // APB answers
    // ----------------------------------------------------------------
    assign pready = 1'b1;
    assign pslverr = acc && !mapped;

    always_comb begin
        case (paddr)
            ndh_pkg::OFF_CTRL: prdata = {29'h0000_0000, s.op};
            ndh_pkg::OFF_TXB: prdata = {24'h00_0000, s.txb};
            ndh_pkg::OFF_COL: prdata = {20'h0_0000, s.col};
            ndh_pkg::OFF_ROW: prdata = {15'h0000, s.row};
            ndh_pkg::OFF_CFG: prdata = {29'h0000_0000, s.ce_keep, s.lock,
                s.wp_n};
            ndh_pkg::OFF_STAT: prdata = {16'h0000, s.rdata, 6'h00, s.rb_s, busy};
            default: prdata = 32'h0000_0000;
        endcase
    end
    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        next_s = s;
        next_s.rb_m = rb_n;
        next_s.rb_s = s.rb_m;
        next_s.io_m = io_in;
        next_s.io_s = s.io_m;
        if (wr && paddr == ndh_pkg::OFF_TXB && !busy) begin
            next_s.txb = pwdata[7:0];
        end
        if (wr && paddr == ndh_pkg::OFF_COL && !busy) begin
            next_s.col = spare_mask(pwdata[11:0]);
        end
        if (wr && paddr == ndh_pkg::OFF_ROW && !busy) begin
            next_s.row = pwdata[16:0];
        end
        if (wr && paddr == ndh_pkg::OFF_CFG && !busy) begin
            next_s.wp_n = pwdata[ndh_pkg::CFG_WP_N];
            next_s.lock = pwdata[ndh_pkg::CFG_LOCK];
            next_s.ce_keep = pwdata[ndh_pkg::CFG_CE_KEEP];
        end
        case (s.st)
            ndh_pkg::ST_IDLE: begin
                next_s.ce_n = !s.ce_keep;
                if (wr && paddr == ndh_pkg::OFF_CTRL
                    && pwdata[2:0] != ndh_pkg::OP_NONE
                    && pwdata[2:0] <= ndh_pkg::OP_ADDR5) begin
                    next_s.op = pwdata[2:0];
                    next_s.idx = 3'h0;
                    next_s.st = ndh_pkg::ST_SETUP;
                end
            end
            ndh_pkg::ST_SETUP: begin
                next_s.ce_n = 1'b0;
                next_s.cle = (s.op == ndh_pkg::OP_CMD);
                next_s.ale = (s.op == ndh_pkg::OP_ADDR)
                    || (s.op == ndh_pkg::OP_ADDR5);
                next_s.io_oe = (s.op != ndh_pkg::OP_RDATA);
                next_s.io_out = (s.op == ndh_pkg::OP_ADDR5)
                    ? addr_byte(s.idx, s.col, s.row) : s.txb;
                next_s.cnt = 4'h0;
                next_s.st = ndh_pkg::ST_PULSE;
            end
            ndh_pkg::ST_PULSE: begin
                if (s.op == ndh_pkg::OP_RDATA) begin
                    next_s.re_n = 1'b0;
                end else begin
                    next_s.we_n = 1'b0;
                end
                if (!s.we_n || !s.re_n) begin
                    next_s.cnt = s.cnt + 4'h1;
                    if (s.cnt == ndh_pkg::STROBE_LAST) begin
                        next_s.we_n = 1'b1;
                        next_s.re_n = 1'b1;
                        if (s.op == ndh_pkg::OP_RDATA) begin
                            next_s.rdata = s.io_s;
                        end
                        next_s.st = ndh_pkg::ST_RELEASE;
                    end
                end
            end
            ndh_pkg::ST_RELEASE: begin
                if (s.op == ndh_pkg::OP_ADDR5
                    && s.idx != ndh_pkg::ADDR_LAST) begin
                    next_s.idx = s.idx + 3'h1;
                    next_s.st = ndh_pkg::ST_SETUP;
                end else begin
                    next_s.cle = 1'b0;
                    next_s.ale = 1'b0;
                    next_s.io_oe = 1'b0;
                    next_s.op = ndh_pkg::OP_NONE;
                    next_s.st = ndh_pkg::ST_IDLE;
                end
            end
            default: begin
                next_s.st = ndh_pkg::ST_IDLE;
            end
        endcase
    end
    // ----------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s <= '0;
            s.st <= ndh_pkg::ST_IDLE;
            s.wp_n <= ndh_pkg::RST_WP_N;
            s.lock <= ndh_pkg::RST_LOCK;
            s.ce_keep <= ndh_pkg::RST_CE_KEEP;
            s.ce_n <= 1'b1;
            s.we_n <= 1'b1;
            s.re_n <= 1'b1;
            s.rb_m <= 1'b1;
            s.rb_s <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    assign ce_n = s.ce_n;
    assign cle = s.cle;
    assign ale = s.ale;
    assign we_n = s.we_n;
    assign read_strobe_n = s.re_n;
    assign io_out = s.io_out;
    assign io_oe = s.io_oe;
    assign wp_n = s.wp_n;
    assign lock = s.lock;
    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_latch_excl: assert property (!(cle && ale))
        else $error("command and address latch high together");
    a_cmd_latch: assert property ($rose(we_n) && cle
        |-> !ce_n && !ale && read_strobe_n)
        else $error("bad command latch cycle");
    a_addr_latch: assert property ($rose(we_n) && ale
        |-> !ce_n && !cle && read_strobe_n)
        else $error("bad address latch cycle");
    a_strobe_ce: assert property (!we_n || !read_strobe_n |-> !ce_n)
        else $error("strobe without chip enable");
    a_bus_turn: assert property (!read_strobe_n |-> !io_oe && we_n)
        else $error("host drives bus during read");
    a_write_pulse: assert property ($fell(we_n)
        |-> !we_n [*3] ##1 we_n && io_oe)
        else $error("write strobe width wrong");
    a_read_pulse: assert property ($fell(read_strobe_n)
        |-> !read_strobe_n [*3] ##1 read_strobe_n)
        else $error("read strobe width wrong");
    a_addr_col_hi: assert property (ale && !we_n
        && s.op == ndh_pkg::OP_ADDR5 && s.idx == 3'h1
        |-> io_out[7:4] == 4'h0)
        else $error("column high cycle upper bits set");
    a_addr_top: assert property (ale && !we_n && s.idx == 3'h4
        |-> io_out[7:1] == 7'h00)
        else $error("fifth address cycle upper bits set");
    a_spare_col: assert property (ale && !we_n
        && s.op == ndh_pkg::OP_ADDR5 && s.idx == 3'h0 && s.col[11]
        |-> io_out[7:6] == 2'h0)
        else $error("spare column with bits 7 to 6 set");
    a_read_take: assert property ($rose(read_strobe_n)
        |-> s.rdata == $past(s.io_s))
        else $error("read data not captured");

    c_cmd: cover property ($rose(we_n) && cle);
    c_addr5: cover property (ale && s.idx == 3'h4 && $rose(we_n));
    c_read: cover property ($rose(read_strobe_n));
endmodule : ndh_host
`default_nettype wire

/* File: tb/ndh_die_model.sv */
// Purpose: Behavioural NAND die seen by the host controller.
// Assumes: Host strobes are slow enough for plain event control.
// Notes: Released bus shows the inverse of the last byte the die drove.
`timescale 1ns/100ps
`default_nettype none
module ndh_die_model (
    // Host-driven pins.
    input wire logic ce_n,
    input wire logic cle,
    input wire logic ale,
    input wire logic we_n,
    input wire logic read_strobe_n,
    input wire logic [7:0] io_out,
    input wire logic io_oe,
    input wire logic wp_n,
    // Die-driven pins.
    output logic [7:0] io_level,
    output logic rb_low
);
    logic [7:0] cmd = 8'h00;
    logic [7:0] dout = 8'h00;
    logic [7:0] abyte [0:4];
    logic [7:0] cache [0:15];
    logic [16:0] row_addr = '0;
    logic [11:0] col_addr = '0;
    logic plane = 1'b0;
    logic doe = 1'b0;
    logic stat_mode = 1'b0;
    int acnt = 0;
    int wptr = 0;
    int rptr = 0;
    logic busy = 1'b0;
    logic ecc_on = 1'b0;
    assign rb_low = 1'b0 | busy;
    assign io_level = io_oe ? io_out : (doe ? dout : ~dout);
    // ----------------------------------------------------------------
    // Write strobe: command, address and data input.
    // ----------------------------------------------------------------
    always @(posedge we_n) begin
        if (!ce_n && read_strobe_n) begin
            if (cle && !ale) begin
                cmd = io_level;
                acnt = 0;
                wptr = 0;
                rptr = 0;
                stat_mode = (io_level == 8'h70);
                if (io_level == 8'hD0 && wp_n) begin
                    fork
                        begin
                            busy = 1'b1;
                            #3000;
                            busy = 1'b0;
                        end
                    join_none
                end
            end else if (ale && !cle && acnt < 5) begin
                abyte[acnt] = io_level;
                acnt++;
                if (acnt == 5) begin
                    col_addr = {abyte[1][3:0], abyte[0]};
                    row_addr = {abyte[4][0], abyte[3], abyte[2]};
                    plane = abyte[2][6];
                end
            end else if (!cle && !ale && !busy) begin
                cache[wptr] = io_level;
                wptr++;
            end
        end
    end
    // ----------------------------------------------------------------
    // Read strobe: drive cache or status byte, release on rise.
    // ----------------------------------------------------------------
    always @(negedge read_strobe_n) begin
        if (!ce_n && !cle && !ale && we_n
            && !busy) begin
            dout = stat_mode ? {wp_n, ~busy, 5'h00, ecc_on} : cache[rptr];
            rptr++;
            doe = 1'b1;
        end
    end
    always @(posedge read_strobe_n or posedge ce_n) begin
        doe = 1'b0;
    end
endmodule : ndh_die_model
`default_nettype wire

/* File: tb/testbench.sv */
// Purpose: Self-checking bench for the NAND bus host controller.
// Assumes: APB master tasks; die model on the far side.
// Notes: Expected values follow from the address layout and field map.
`timescale 1ns/100ps
`default_nettype none
module testbench;
    logic pclk = 1'b0;
    logic presetn, psel, penable, pwrite, pready, pslverr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, r;
    logic ce_n, cle, ale, we_n, read_strobe_n, io_oe, wp_n, lock, rb_low;
    logic [7:0] io_out, io_in;
    logic e;
    int mismatches = 0;
    int check_count = 0;
    always #50 pclk = ~pclk;
    ndh_host u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .ce_n(ce_n),
        .cle(cle), .ale(ale), .we_n(we_n), .read_strobe_n(read_strobe_n),
        .io_out(io_out), .io_oe(io_oe), .io_in(io_in), .wp_n(wp_n),
        .lock(lock), .rb_n(rb_low ? 1'b0 : 1'b1));
    ndh_die_model u_die (.ce_n(ce_n), .cle(cle), .ale(ale), .we_n(we_n),
        .read_strobe_n(read_strobe_n), .io_out(io_out), .io_oe(io_oe),
        .wp_n(wp_n), .io_level(io_in), .rb_low(rb_low));
    // ----------------------------------------------------------------
    // Bus and compare tasks.
    // ----------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [7:0] a,
            input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic rdm(input logic [7:0] a, input logic [31:0] m,
            input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000);
        chk(r & m, exp);
    endtask : rdm
    task automatic poll(input int bit_no, input logic want);
        int n;
        n = 0;
        do begin
            apb(1'b0, ndh_pkg::OFF_STAT, 32'h0000_0000);
            n++;
        end while (r[bit_no] !== want && n < 80);
        chk(32'(r[bit_no]), 32'(want));
    endtask : poll
    task automatic run(input logic [2:0] op, input logic [7:0] b);
        apb(1'b1, ndh_pkg::OFF_TXB, 32'(b));
        apb(1'b1, ndh_pkg::OFF_CTRL, 32'(op));
        poll(ndh_pkg::STAT_BUSY, 1'b0);
    endtask : run
    task automatic end_of_test();
        $display("mismatches=%0d check_count=%0d", mismatches, check_count);
        if (mismatches == 0 && check_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : end_of_test
    initial begin
        #500_000;
        mismatches++;
        end_of_test();
    end
    // ----------------------------------------------------------------
    // Test sequence.
    // ----------------------------------------------------------------
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        chk(32'({ce_n, cle, ale, we_n, read_strobe_n, io_oe, wp_n, lock}),
            32'h0000_0098);
        rdm(ndh_pkg::OFF_CFG, 32'h0000_0007, 32'h0000_0000);
        rdm(ndh_pkg::OFF_STAT, 32'h0000_FFFF, 32'h0000_0002);
        rdm(8'h18, 32'hFFFF_FFFF, 32'h0000_0000);
        chk(32'(e), 32'h0000_0001);
        apb(1'b1, ndh_pkg::OFF_CFG, 32'h0000_0003);
        @(posedge pclk);
        chk(32'({wp_n, lock}), 32'h0000_0003);
        run(ndh_pkg::OP_CMD, 8'h70);
        chk(32'(u_die.cmd), 32'h0000_0070);
        run(ndh_pkg::OP_RDATA, 8'h00);
        rdm(ndh_pkg::OFF_STAT, 32'h0000_FF00, 32'h0000_C000);
        apb(1'b1, ndh_pkg::OFF_COL, 32'h0000_0FFF);
        rdm(ndh_pkg::OFF_COL, 32'h0000_0FFF, 32'h0000_083F);
        apb(1'b1, ndh_pkg::OFF_ROW, 32'h0001_2345);
        run(ndh_pkg::OP_ADDR5, 8'h00);
        chk(32'(u_die.col_addr), 32'h0000_083F);
        chk(32'(u_die.row_addr), 32'h0001_2345);
        chk(32'(u_die.plane), 32'h0000_0001);
        run(ndh_pkg::OP_CMD, 8'h00);
        run(ndh_pkg::OP_ADDR, 8'h07);
        chk(32'(u_die.abyte[0]), 32'h0000_0007);
        run(ndh_pkg::OP_CMD, 8'h80);
        run(ndh_pkg::OP_WDATA, 8'hC3);
        run(ndh_pkg::OP_WDATA, 8'h96);
        chk(32'(u_die.wptr), 32'h0000_0002);
        run(ndh_pkg::OP_CMD, 8'h30);
        run(ndh_pkg::OP_RDATA, 8'h00);
        rdm(ndh_pkg::OFF_STAT, 32'h0000_FF00, 32'h0000_C300);
        run(ndh_pkg::OP_RDATA, 8'h00);
        rdm(ndh_pkg::OFF_STAT, 32'h0000_FF00, 32'h0000_9600);
        apb(1'b1, ndh_pkg::OFF_TXB, 32'h0000_00D0);
        apb(1'b1, ndh_pkg::OFF_CTRL, 32'(ndh_pkg::OP_CMD));
        apb(1'b1, ndh_pkg::OFF_TXB, 32'h0000_0011);
        poll(ndh_pkg::STAT_BUSY, 1'b0);
        rdm(ndh_pkg::OFF_TXB, 32'h0000_00FF, 32'h0000_00D0);
        rdm(ndh_pkg::OFF_STAT, 32'h0000_0002, 32'h0000_0000);
        poll(ndh_pkg::STAT_RDY, 1'b1);
        apb(1'b1, ndh_pkg::OFF_CFG, 32'h0000_0000);
        run(ndh_pkg::OP_CMD, 8'hD0);
        rdm(ndh_pkg::OFF_STAT, 32'h0000_0002, 32'h0000_0002);
        run(ndh_pkg::OP_CMD, 8'h70);
        run(ndh_pkg::OP_RDATA, 8'h00);
        rdm(ndh_pkg::OFF_STAT, 32'h0000_FF00, 32'h0000_4000);
        apb(1'b1, ndh_pkg::OFF_CTRL, 32'h0000_0006);
        rdm(ndh_pkg::OFF_STAT, 32'h0000_0001, 32'h0000_0000);
        chk(32'({ce_n, cle, ale}), 32'h0000_0004);
        apb(1'b1, ndh_pkg::OFF_CFG, 32'h0000_0004);
        repeat (2) @(posedge pclk);
        chk(32'(ce_n), 32'h0000_0000);
        presetn <= 1'b0;
        @(posedge pclk);
        chk(32'({ce_n, we_n, read_strobe_n}), 32'h0000_0007);
        presetn <= 1'b1;
        rdm(ndh_pkg::OFF_CFG, 32'h0000_0007, 32'h0000_0000);
        run(ndh_pkg::OP_CMD, 8'h00);
        chk(32'(u_die.cmd), 32'h0000_0000);
        end_of_test();
    end
endmodule : testbench
`default_nettype wire
